// [design/mpfsel_pkg.sv]
// Package with register map, function codes and control-vector layout of the pin function select block
`default_nettype none
package mpfsel_pkg;
    localparam int           ADDR_W            = 8;
    localparam int           DATA_W            = 8;
    localparam int           SEL_W             = 5;

    localparam logic [7:0]   ADDR_MIC01        = 8'h3c;
    localparam logic [7:0]   ADDR_MIC23        = 8'h3d;
    localparam logic [7:0]   ADDR_SOUT1        = 8'h3e;

    localparam logic [7:0]   RST_MIC01         = 8'h00;
    localparam logic [7:0]   RST_MIC23         = 8'h00;
    localparam logic [7:0]   RST_SOUT1         = 8'h11;
    localparam logic [7:0]   RDATA_UNMAPPED    = 8'h00;

    localparam int           SEL_MSB           = 4;
    localparam int           SEL_LSB           = 0;

    localparam logic [4:0]   CODE_PRIMARY      = 5'h00;
    localparam logic [4:0]   CODE_MUTE_ADC0    = 5'h01;
    localparam logic [4:0]   CODE_MUTE_ADC1    = 5'h02;
    localparam logic [4:0]   CODE_MUTE_ADC2    = 5'h03;
    localparam logic [4:0]   CODE_MUTE_ADC3    = 5'h04;
    localparam logic [4:0]   CODE_MUTE_ADC01   = 5'h05;
    localparam logic [4:0]   CODE_MUTE_ADC23   = 5'h06;
    localparam logic [4:0]   CODE_MUTE_ADC_ALL = 5'h07;
    localparam logic [4:0]   CODE_MUTE_DAC0    = 5'h08;
    localparam logic [4:0]   CODE_MUTE_DAC1    = 5'h09;
    localparam logic [4:0]   CODE_MUTE_DAC_ALL = 5'h0a;
    localparam logic [4:0]   CODE_BANK_SWITCH  = 5'h0b;
    localparam logic [4:0]   CODE_COMPRESSION  = 5'h0e;
    localparam logic [4:0]   CODE_DSP_BYPASS   = 5'h0f;
    localparam logic [4:0]   CODE_VOL_UP       = 5'h10;
    localparam logic [4:0]   CODE_VOL_DOWN     = 5'h11;
    localparam logic [4:0]   CODE_CLOCK_OUT    = 5'h12;

    // Control vector bit positions
    localparam int           CTL_ADC0          = 0;
    localparam int           CTL_ADC1          = 1;
    localparam int           CTL_ADC2          = 2;
    localparam int           CTL_ADC3          = 3;
    localparam int           CTL_DAC0          = 4;
    localparam int           CTL_DAC1          = 5;
    localparam int           CTL_BANK          = 6;
    localparam int           CTL_COMP          = 7;
    localparam int           CTL_BYPASS        = 8;
    localparam int           CTL_VOL_UP        = 9;
    localparam int           CTL_VOL_DOWN      = 10;
    localparam int           CTL_W             = 11;

    typedef logic [CTL_W-1:0] mpfsel_ctl_t;

    localparam mpfsel_ctl_t  CTL_NONE          = 11'h000;

    // Reserved and non-control codes give no action
    function automatic mpfsel_ctl_t mpfsel_decode(input logic [SEL_W-1:0] code);
        mpfsel_ctl_t c;
        c = CTL_NONE;
        unique case (code)
            CODE_MUTE_ADC0:    c[CTL_ADC0] = 1'b1;
            CODE_MUTE_ADC1:    c[CTL_ADC1] = 1'b1;
            CODE_MUTE_ADC2:    c[CTL_ADC2] = 1'b1;
            CODE_MUTE_ADC3:    c[CTL_ADC3] = 1'b1;
            CODE_MUTE_ADC01: begin
                c[CTL_ADC0] = 1'b1;
                c[CTL_ADC1] = 1'b1;
            end
            CODE_MUTE_ADC23: begin
                c[CTL_ADC2] = 1'b1;
                c[CTL_ADC3] = 1'b1;
            end
            CODE_MUTE_ADC_ALL: begin
                c[CTL_ADC0] = 1'b1;
                c[CTL_ADC1] = 1'b1;
                c[CTL_ADC2] = 1'b1;
                c[CTL_ADC3] = 1'b1;
            end
            CODE_MUTE_DAC0:    c[CTL_DAC0] = 1'b1;
            CODE_MUTE_DAC1:    c[CTL_DAC1] = 1'b1;
            CODE_MUTE_DAC_ALL: begin
                c[CTL_DAC0] = 1'b1;
                c[CTL_DAC1] = 1'b1;
            end
            CODE_BANK_SWITCH:  c[CTL_BANK] = 1'b1;
            CODE_COMPRESSION:  c[CTL_COMP] = 1'b1;
            CODE_DSP_BYPASS:   c[CTL_BYPASS] = 1'b1;
            CODE_VOL_UP:       c[CTL_VOL_UP] = 1'b1;
            CODE_VOL_DOWN:     c[CTL_VOL_DOWN] = 1'b1;
            default:           c = CTL_NONE;
        endcase
        return c;
    endfunction
endpackage
`default_nettype wire

// [design/mpfsel_pin.sv]
// One multipurpose pin: input synchroniser and control-function decode
`default_nettype none
module mpfsel_pin
    import mpfsel_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    input  wire logic              clk_en_in,
    input  wire logic              pin_in,
    input  wire logic [SEL_W-1:0]  select_in,
    output logic                   level_out,
    output mpfsel_ctl_t            ctl_out
);
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        mpfsel_ctl_t ctl;
    } mpfsel_pin_s;

    localparam mpfsel_pin_s PIN_RST = '{sync1: 1'b0, sync2: 1'b0, ctl: CTL_NONE};

    mpfsel_pin_s st_reg;
    mpfsel_pin_s st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pin_in;
        st_next.sync2 = st_reg.sync1;
        // Action lasts as long as the synchronised pin is high
        st_next.ctl   = st_reg.sync2 ? mpfsel_decode(select_in) : CTL_NONE;
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= PIN_RST;
        end else if (clk_en_in) begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.sync2;
    assign ctl_out   = st_reg.ctl;
endmodule
`default_nettype wire

// [design/mpfsel_top.sv]
// Function select for the two microphone pins and the second serial output / clock output pin
//
// The strobed register port was left to the implementer.
`default_nettype none
module mpfsel_top
    import mpfsel_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    input  wire logic              clk_en_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [DATA_W-1:0]      reg_rdata_out,
    input  wire logic              multipurpose_pin_four_in,
    input  wire logic              multipurpose_pin_five_in,
    input  wire logic              multipurpose_pin_six_in,
    output logic                   multipurpose_pin_six_out,
    output logic                   multipurpose_pin_six_oe_n_out,
    input  wire logic              serial_audio_output_one_in,
    input  wire logic              clock_output_function_in,
    output logic                   mic_pair_zero_one_input_out,
    output logic                   mic_pair_zero_one_valid_out,
    output logic                   mic_pair_two_three_input_out,
    output logic                   mic_pair_two_three_valid_out,
    output logic [3:0]             adc_mute_out,
    output logic [1:0]             dac_mute_out,
    output logic                   bank_switch_out,
    output logic                   compression_out,
    output logic                   dsp_bypass_out,
    output logic                   vol_up_out,
    output logic                   vol_down_out
);
    typedef struct packed {
        logic [DATA_W-1:0] mic01_pin_function;
        logic [DATA_W-1:0] mic23_pin_function;
        logic [DATA_W-1:0] serial_out1_pin_function;
        logic [DATA_W-1:0] rdata;
        logic              pin6_drive;
        logic              pin6_oe_n;
        logic              mic01_data;
        logic              mic01_valid;
        logic              mic23_data;
        logic              mic23_valid;
        mpfsel_ctl_t       ctl;
    } mpfsel_top_s;

    localparam mpfsel_top_s TOP_RST = '{
        mic01_pin_function:       RST_MIC01,
        mic23_pin_function:       RST_MIC23,
        serial_out1_pin_function: RST_SOUT1,
        rdata:                    RDATA_UNMAPPED,
        pin6_drive:               1'b0,
        pin6_oe_n:                1'b1,
        mic01_data:               1'b0,
        mic01_valid:              1'b0,
        mic23_data:               1'b0,
        mic23_valid:              1'b0,
        ctl:                      CTL_NONE
    };

    mpfsel_top_s st_reg;
    mpfsel_top_s st_next;

    logic [SEL_W-1:0] mic01_pin_select;
    logic [SEL_W-1:0] mic23_pin_select;
    logic [SEL_W-1:0] serial_out1_pin_select;
    logic             mic01_level;
    logic             mic23_level;
    mpfsel_ctl_t      mic01_ctl;
    mpfsel_ctl_t      mic23_ctl;
    mpfsel_ctl_t      pin6_ctl;

    // Only the select field steers the pins; the upper bits are kept for readback
    assign mic01_pin_select       = st_reg.mic01_pin_function[SEL_MSB:SEL_LSB];
    assign mic23_pin_select       = st_reg.mic23_pin_function[SEL_MSB:SEL_LSB];
    assign serial_out1_pin_select = st_reg.serial_out1_pin_function[SEL_MSB:SEL_LSB];

    mpfsel_pin u_pin_four (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .clk_en_in (clk_en_in),
        .pin_in    (multipurpose_pin_four_in),
        .select_in (mic01_pin_select),
        .level_out (mic01_level),
        .ctl_out   (mic01_ctl)
    );

    mpfsel_pin u_pin_five (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .clk_en_in (clk_en_in),
        .pin_in    (multipurpose_pin_five_in),
        .select_in (mic23_pin_select),
        .level_out (mic23_level),
        .ctl_out   (mic23_ctl)
    );

    mpfsel_pin u_pin_six (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .clk_en_in (clk_en_in),
        .pin_in    (multipurpose_pin_six_in),
        .select_in (serial_out1_pin_select),
        .level_out (),
        .ctl_out   (pin6_ctl)
    );

    always_comb begin
        st_next = st_reg;

        // Register writes
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ADDR_MIC01: st_next.mic01_pin_function       = reg_wdata_in;
                ADDR_MIC23: st_next.mic23_pin_function       = reg_wdata_in;
                ADDR_SOUT1: st_next.serial_out1_pin_function = reg_wdata_in;
                default:    st_next.mic01_pin_function       = st_reg.mic01_pin_function;
            endcase
        end

        // Read data stands only in the cycle after the strobe
        st_next.rdata = RDATA_UNMAPPED;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_MIC01: st_next.rdata = st_reg.mic01_pin_function;
                ADDR_MIC23: st_next.rdata = st_reg.mic23_pin_function;
                ADDR_SOUT1: st_next.rdata = st_reg.serial_out1_pin_function;
                default:    st_next.rdata = RDATA_UNMAPPED;
            endcase
        end

        // Microphone data passes only while the pin keeps its primary role
        st_next.mic01_valid = (mic01_pin_select == CODE_PRIMARY);
        st_next.mic01_data  = st_next.mic01_valid ? mic01_level : 1'b0;
        st_next.mic23_valid = (mic23_pin_select == CODE_PRIMARY);
        st_next.mic23_data  = st_next.mic23_valid ? mic23_level : 1'b0;

        // Pin six drives serial data or the clock, else is released as an input
        unique case (serial_out1_pin_select)
            CODE_PRIMARY: begin
                st_next.pin6_drive = serial_audio_output_one_in;
                st_next.pin6_oe_n  = 1'b0;
            end
            CODE_CLOCK_OUT: begin
                st_next.pin6_drive = clock_output_function_in;
                st_next.pin6_oe_n  = 1'b0;
            end
            default: begin
                st_next.pin6_drive = 1'b0;
                st_next.pin6_oe_n  = 1'b1;
            end
        endcase

        // Any pin asserting a function raises it
        st_next.ctl = mic01_ctl | mic23_ctl | pin6_ctl;
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= TOP_RST;
        end else if (clk_en_in) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out                 = st_reg.rdata;
    assign multipurpose_pin_six_out      = st_reg.pin6_drive;
    assign multipurpose_pin_six_oe_n_out = st_reg.pin6_oe_n;
    assign mic_pair_zero_one_input_out   = st_reg.mic01_data;
    assign mic_pair_zero_one_valid_out   = st_reg.mic01_valid;
    assign mic_pair_two_three_input_out  = st_reg.mic23_data;
    assign mic_pair_two_three_valid_out  = st_reg.mic23_valid;
    assign adc_mute_out                  = {st_reg.ctl[CTL_ADC3], st_reg.ctl[CTL_ADC2],
                                            st_reg.ctl[CTL_ADC1], st_reg.ctl[CTL_ADC0]};
    assign dac_mute_out                  = {st_reg.ctl[CTL_DAC1], st_reg.ctl[CTL_DAC0]};
    assign bank_switch_out               = st_reg.ctl[CTL_BANK];
    assign compression_out               = st_reg.ctl[CTL_COMP];
    assign dsp_bypass_out                = st_reg.ctl[CTL_BYPASS];
    assign vol_up_out                    = st_reg.ctl[CTL_VOL_UP];
    assign vol_down_out                  = st_reg.ctl[CTL_VOL_DOWN];
endmodule
`default_nettype wire

// [verification/mpfsel_top_chk.sv]
// Checker for register access, pin six enable and control timing
`default_nettype none
module mpfsel_top_chk
    import mpfsel_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    input  wire logic              clk_en_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire logic [DATA_W-1:0] reg_rdata_out,
    input  wire logic              multipurpose_pin_four_in,
    input  wire logic              multipurpose_pin_six_oe_n_out,
    input  wire logic              mic_pair_zero_one_input_out,
    input  wire logic              mic_pair_zero_one_valid_out,
    input  wire logic [3:0]        adc_mute_out,
    input  wire logic [1:0]        dac_mute_out
);
    logic [4:0] s4, s5, s6, p4, p6;
    logic       live, mapped, any_ctl;
    function automatic logic is_ctl(input logic [4:0] c);
        return c inside {[5'h01:5'h0b], [5'h0e:5'h11]};
    endfunction
    assign mapped = reg_addr_in inside {ADDR_MIC01, ADDR_MIC23, ADDR_SOUT1};
    assign any_ctl = is_ctl(s4) || is_ctl(s5) || is_ctl(s6);
    // Shadow of the select fields and one-cycle-old copies of the pin four and pin six fields
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {s4, s5, s6} <= {RST_MIC01[4:0], RST_MIC23[4:0], RST_SOUT1[4:0]};
            {p4, p6, live} <= {RST_MIC01[4:0], RST_SOUT1[4:0], 1'b0};
        end else if (clk_en_in) begin
            if (reg_wr_in && reg_addr_in == ADDR_MIC01) s4 <= reg_wdata_in[4:0];
            if (reg_wr_in && reg_addr_in == ADDR_MIC23) s5 <= reg_wdata_in[4:0];
            if (reg_wr_in && reg_addr_in == ADDR_SOUT1) s6 <= reg_wdata_in[4:0];
            {p4, p6, live} <= {s4, s6, 1'b1};
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    a_unmapped_read: assert property (reg_rd_in && !mapped |=> reg_rdata_out == RDATA_UNMAPPED)
        else $error("unmapped read not zero");
    a_write_readback: assert property (reg_wr_in && mapped ##1 reg_rd_in && reg_addr_in == $past(reg_addr_in)
        |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("read after write wrong");
    a_six_enable: assert property (multipurpose_pin_six_oe_n_out == !(p6 inside {5'h00, 5'h12}))
        else $error("pin six enable wrong");
    a_mic_valid: assert property (live |-> mic_pair_zero_one_valid_out == (p4 == 5'h00))
        else $error("mic valid wrong");
    a_mic_data: assert property ((s4 == 5'h00)[*4]
        |-> mic_pair_zero_one_input_out == $past(multipurpose_pin_four_in, 3)) else $error("mic data wrong");
    a_no_control: assert property ((!any_ctl)[*4] |-> {adc_mute_out, dac_mute_out} == 6'h00)
        else $error("control without select");
    a_mute_latency: assert property ((s4 == 5'h01 && !is_ctl(s5) && !is_ctl(s6))[*4]
        |-> adc_mute_out[0] == $past(multipurpose_pin_four_in, 4)) else $error("mute timing wrong");
    c_clock_out: cover property (!multipurpose_pin_six_oe_n_out && p6 == 5'h12);
    c_unmapped: cover property (reg_rd_in && !mapped);
    c_mute_rise: cover property ($rose(adc_mute_out[0]));
endmodule
bind mpfsel_top mpfsel_top_chk u_chk (.*);
`default_nettype wire

// [verification/mpfsel_far_model.sv]
// Far-side model: push buttons on the three pins, pin six shared with the device driver
`default_nettype none
module mpfsel_far_model (
    input  wire logic       mclk_in,
    input  wire logic       slow_in,
    input  wire logic [2:0] press_in,
    input  wire logic       drv_in,
    input  wire logic       drv_oe_n_in,
    output logic [2:0]      pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] late;
    logic [2:0] lvl;
    always @(posedge mclk_in) late <= press_in;
    assign lvl = slow_in ? late : press_in;
    // Device drive wins while its enable is low
    assign pin_out = {drv_oe_n_in ? lvl[2] : drv_in, lvl[1:0]};
endmodule
`default_nettype wire

// [verification/test_mpfsel_top.sv]
// Self-checking testbench for the pin function select block
`default_nettype none
module test_mpfsel_top
    import mpfsel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [10:0] EXP [0:18] = '{11'h000, 11'h001, 11'h002, 11'h004, 11'h008, 11'h003, 11'h00c,
        11'h00f, 11'h010, 11'h020, 11'h030, 11'h040, 11'h000, 11'h000, 11'h080, 11'h100, 11'h200, 11'h400, 11'h000};
    logic        mclk_in, nrst_in, clk_en_in, reg_wr_in, reg_rd_in, slow;
    logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic        multipurpose_pin_four_in, multipurpose_pin_five_in, multipurpose_pin_six_in;
    logic        multipurpose_pin_six_out, multipurpose_pin_six_oe_n_out;
    logic        serial_audio_output_one_in, clock_output_function_in;
    logic        mic_pair_zero_one_input_out, mic_pair_zero_one_valid_out;
    logic        mic_pair_two_three_input_out, mic_pair_two_three_valid_out;
    logic        bank_switch_out, compression_out, dsp_bypass_out, vol_up_out, vol_down_out;
    logic [3:0]  adc_mute_out;
    logic [1:0]  dac_mute_out;
    logic [2:0]  press;
    logic [10:0] ctl;
    int          bad_count, samples_checked;
    assign ctl = {vol_down_out, vol_up_out, dsp_bypass_out, compression_out, bank_switch_out,
                  dac_mute_out, adc_mute_out};
    logic [2:0]  far_pins;
    assign {multipurpose_pin_six_in, multipurpose_pin_five_in, multipurpose_pin_four_in} = far_pins;
    mpfsel_top u_dut (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .multipurpose_pin_four_in(multipurpose_pin_four_in),
        .multipurpose_pin_five_in(multipurpose_pin_five_in),
        .multipurpose_pin_six_in(multipurpose_pin_six_in),
        .multipurpose_pin_six_out(multipurpose_pin_six_out),
        .multipurpose_pin_six_oe_n_out(multipurpose_pin_six_oe_n_out),
        .serial_audio_output_one_in(serial_audio_output_one_in),
        .clock_output_function_in(clock_output_function_in),
        .mic_pair_zero_one_input_out(mic_pair_zero_one_input_out),
        .mic_pair_zero_one_valid_out(mic_pair_zero_one_valid_out),
        .mic_pair_two_three_input_out(mic_pair_two_three_input_out),
        .mic_pair_two_three_valid_out(mic_pair_two_three_valid_out),
        .adc_mute_out(adc_mute_out), .dac_mute_out(dac_mute_out), .bank_switch_out(bank_switch_out),
        .compression_out(compression_out), .dsp_bypass_out(dsp_bypass_out), .vol_up_out(vol_up_out),
        .vol_down_out(vol_down_out));
    mpfsel_far_model u_far (.mclk_in(mclk_in), .slow_in(slow), .press_in(press), .drv_in(multipurpose_pin_six_out),
        .drv_oe_n_in(multipurpose_pin_six_oe_n_out),
        .pin_out(far_pins));
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) clock_output_function_in <= ~clock_output_function_in;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= d;
    endtask
    task automatic idle(input int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        op(1'b0, 1'b1, a, 8'h00);
        idle(1);
        chk(reg_rdata_out, exp);
    endtask
    task automatic t_reset;
        @(posedge mclk_in) {nrst_in, reg_wr_in, reg_rd_in} <= 3'b000;
        repeat (12) @(posedge mclk_in);
        nrst_in <= 1'b1;
        rd(8'h3c, 8'h00);
        rd(8'h3d, 8'h00);
        rd(8'h3e, 8'h11);
        rd(8'h3f, 8'h00);
        chk({mic_pair_zero_one_valid_out, mic_pair_two_three_valid_out}, 2'b11);
        @(posedge mclk_in) {slow, press} <= 4'b1100;
        idle(5);
        chk({vol_down_out, multipurpose_pin_six_oe_n_out}, 2'b11);
        @(posedge mclk_in) {slow, press} <= 4'b0000;
        $display("reset test done");
    endtask
    task automatic t_regs;
        for (int i = 0; i < 3; i++) begin
            op(1'b1, 1'b0, 8'h3c + 8'(i), 8'he0);
            rd(8'h3c + 8'(i), 8'he0);
        end
        op(1'b1, 1'b0, 8'h3f, 8'h5a);
        rd(8'h3f, 8'h00);
        // A write while the clock enable is low is lost
        @(posedge mclk_in) clk_en_in <= 1'b0;
        op(1'b1, 1'b0, 8'h3d, 8'h0f);
        @(posedge mclk_in) {clk_en_in, reg_wr_in} <= 2'b10;
        rd(8'h3d, 8'he0);
        chk({mic_pair_zero_one_valid_out, mic_pair_two_three_valid_out}, 2'b11);
        chk({multipurpose_pin_six_oe_n_out, multipurpose_pin_six_out}, 2'b01);
        $display("register test done");
    endtask
    // Every code on every pin, with the button pressed and then released
    task automatic t_codes;
        for (int p = 0; p < 3; p++) begin
            for (int c = 0; c < 32; c++) begin
                op(1'b1, 1'b0, 8'h3c + 8'(p), {3'b101, 5'(c)});
                press <= 3'(1 << p);
                idle(5);
                chk(ctl, c < 19 ? EXP[c] : 11'h000);
                if (p == 2) chk(multipurpose_pin_six_oe_n_out, !(c == 0 || c == 18));
                else chk(p ? {mic_pair_two_three_valid_out, mic_pair_two_three_input_out}
                           : {mic_pair_zero_one_valid_out, mic_pair_zero_one_input_out}, {c == 0, c == 0});
                @(posedge mclk_in) press <= 3'b000;
                idle(5);
                chk(ctl, 11'h000);
            end
            op(1'b1, 1'b0, 8'h3c + 8'(p), 8'h00);
        end
        $display("function code test done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        {nrst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, slow, press} = '0;
        {clk_en_in, serial_audio_output_one_in, clock_output_function_in} = 3'b110;
        bad_count = 0;
        samples_checked = 0;
        t_reset();
        t_regs();
        t_codes();
        t_reset();
        close_out();
    end
    // The tests need about 12 us
    initial begin
        #50000;
        bad_count++;
        close_out();
    end
endmodule
`default_nettype wire
